// *** rtl/bsts_exec.sv ***
// module: executes bit set and bit test skip instructions over four phases
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - bit set forces chosen bit, no flags
// - access flag zero uses the access bank
// - access flag one uses bank select register
// - extended set, address up to 95 indexed
// - skip on clear bit or set bit
// - skip discards fetched word, runs no-operation
module bsts_exec (
    input wire logic clk_sys, // phase clock, four edges per cycle
    input wire logic rst, // asynchronous reset, active high
    input wire logic [15:0] opcode, // instruction word latched at decode
    input wire logic ext_set_en, // extended instruction set enabled
    input wire logic [3:0] bank_select_reg, // bank select register
    input wire logic [11:0] index_base, // base pointer for indexed mode
    input wire logic [7:0] rd_data, // data memory read value
    output logic [11:0] mem_addr, // data memory address
    output logic mem_rd, // read strobe in second phase
    output logic mem_wr, // write strobe in fourth phase
    output logic [7:0] wr_data, // value written back
    output logic [1:0] phase, // current phase, 0 is the first
    output logic exec_nop, // current cycle is a forced no-operation
    output logic skip_taken, // pulse at cycle end when skipping
    output logic indexed_mode // last access used indexed mode
);
    import bsts_pkg::*;
    logic [1:0] phase_reg, phase_next;
    bsts_op_e op_reg, op_next;
    logic [2:0] bitn_reg, bitn_next;
    logic [11:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic rd_reg, rd_next, wr_reg, wr_next;
    logic nop_reg, nop_next, skip_reg, skip_next, pend_reg, pend_next;
    logic idx_reg, idx_next;
    logic [11:0] res_addr;
    logic res_idx;

    bsts_addr_resolve u_resolve (
        .reg_addr(opcode[7:0]),
        .access_flag(opcode[BSTS_ACC_POS]),
        .ext_set_en(ext_set_en),
        .bank_select_reg(bank_select_reg),
        .index_base(index_base),
        .data_addr(res_addr),
        .indexed(res_idx)
    );

    always_comb begin
        phase_next = phase_reg + 2'h1;
        op_next = op_reg;
        bitn_next = bitn_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        rd_next = 1'b0;
        wr_next = 1'b0;
        nop_next = nop_reg;
        skip_next = 1'b0;
        pend_next = pend_reg;
        idx_next = idx_reg;
        unique case (phase_reg)
            BSTS_Q1: begin
                // decode; a pending skip turns this cycle into a nop
                if (pend_reg) begin
                    nop_next = 1'b1;
                    pend_next = 1'b0;
                    op_next = BSTS_OP_NONE;
                end else begin
                    nop_next = 1'b0;
                    bitn_next = opcode[BSTS_BIT_POS +: 3];
                    addr_next = res_addr;
                    idx_next = res_idx;
                    unique case (opcode[BSTS_NIB_POS +: 4])
                        BSTS_NIB_SET: op_next = BSTS_OP_SET;
                        BSTS_NIB_SKIP_CLR: op_next = BSTS_OP_SKIP_CLR;
                        BSTS_NIB_SKIP_SET: op_next = BSTS_OP_SKIP_SET;
                        default: op_next = BSTS_OP_NONE;
                    endcase
                    rd_next = 1'b1;
                end
            end
            BSTS_Q2: begin
                if (op_reg != BSTS_OP_NONE) begin
                    data_next = rd_data;
                end
            end
            BSTS_Q3: begin
                if (op_reg == BSTS_OP_SET) begin
                    // only the chosen bit changes; status is untouched
                    data_next = data_reg | (8'h01 << bitn_reg);
                    wr_next = 1'b1;
                end else if (op_reg == BSTS_OP_SKIP_CLR) begin
                    skip_next = ~data_reg[bitn_reg];
                    pend_next = ~data_reg[bitn_reg];
                end else if (op_reg == BSTS_OP_SKIP_SET) begin
                    skip_next = data_reg[bitn_reg];
                    pend_next = data_reg[bitn_reg];
                end
            end
            BSTS_Q4: begin
            end
        endcase
        if (rd_reg) begin
            rd_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_reg <= BSTS_Q1;
            op_reg <= BSTS_OP_NONE;
            bitn_reg <= 3'h0;
            addr_reg <= BSTS_ADDR_RST;
            data_reg <= BSTS_DATA_RST;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            nop_reg <= 1'b0;
            skip_reg <= 1'b0;
            pend_reg <= 1'b0;
            idx_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            op_reg <= op_next;
            bitn_reg <= bitn_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            nop_reg <= nop_next;
            skip_reg <= skip_next;
            pend_reg <= pend_next;
            idx_reg <= idx_next;
        end
    end

    assign mem_addr = addr_reg;
    assign mem_rd = rd_reg;
    assign mem_wr = wr_reg;
    assign wr_data = data_reg;
    assign phase = phase_reg;
    assign exec_nop = nop_reg;
    assign skip_taken = skip_reg;
    assign indexed_mode = idx_reg;

    // checks sample on the phase clock; expectations come from the opcode
    // fields as they stood at the decode edge

    a_set_writes_bit: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_wr |-> wr_data[bitn_reg] == 1'b1 && phase == BSTS_Q4)
        else $error("bit set write lacks the set bit");
    a_set_keeps_rest: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q3 && op_reg == BSTS_OP_SET)
        |=> (wr_data | (8'h01 << bitn_reg)) ==
            ($past(data_reg) | (8'h01 << bitn_reg)))
        else $error("bit set changed other bits");
    a_bank_select: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q1 && !pend_reg && opcode[BSTS_ACC_POS])
        |=> mem_addr == {$past(bank_select_reg), $past(opcode[7:0])})
        else $error("banked address wrong");
    a_bank_direct: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q1 && !pend_reg && opcode[BSTS_ACC_POS])
        |=> !indexed_mode)
        else $error("banked access took indexed mode");
    a_access_bank: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q1 && !pend_reg && !opcode[BSTS_ACC_POS]
         && !ext_set_en) |=> mem_addr[7:0] == $past(opcode[7:0])
         && !indexed_mode)
        else $error("access bank address wrong");
    a_access_page: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q1 && !pend_reg && !opcode[BSTS_ACC_POS]
         && !(ext_set_en && opcode[7:0] <= BSTS_IDX_LIMIT))
        |=> mem_addr[11:8] == ($past(opcode[7]) ? 4'hF : 4'h0))
        else $error("access bank page wrong");
    a_indexed_mode: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q1 && !pend_reg && !opcode[BSTS_ACC_POS]
         && ext_set_en && opcode[7:0] <= BSTS_IDX_LIMIT)
        |=> indexed_mode)
        else $error("indexed mode not used");
    a_indexed_addr: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q1 && !pend_reg && !opcode[BSTS_ACC_POS]
         && ext_set_en && opcode[7:0] <= BSTS_IDX_LIMIT)
        |=> mem_addr == 12'($past(index_base) + $past(opcode[7:0])))
        else $error("indexed address wrong");
    a_skip_clear: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q3 && op_reg == BSTS_OP_SKIP_CLR)
        |=> skip_taken == !$past(data_reg[bitn_reg]))
        else $error("skip on clear wrong");
    a_skip_set: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q3 && op_reg == BSTS_OP_SKIP_SET)
        |=> skip_taken == $past(data_reg[bitn_reg]))
        else $error("skip on set wrong");
    a_skip_phase: assert property (
        @(posedge clk_sys) disable iff (rst)
        skip_taken |-> phase == BSTS_Q4 && op_reg != BSTS_OP_SET)
        else $error("skip outside the end of a test");
    a_test_no_write: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q3 && op_reg != BSTS_OP_SET) |=> !mem_wr)
        else $error("bit test wrote the register");
    a_skip_nop: assert property (
        @(posedge clk_sys) disable iff (rst)
        skip_taken |=> ##1 (exec_nop && !mem_rd) [*4])
        else $error("skip did not run a nop cycle");
    a_nop_no_decode: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == BSTS_Q1 && pend_reg)
        |=> exec_nop && !mem_rd && op_reg == BSTS_OP_NONE)
        else $error("discarded word was decoded");
    a_nop_quiet: assert property (
        @(posedge clk_sys) disable iff (rst)
        exec_nop |-> !mem_wr && !skip_taken)
        else $error("forced nop changed state");
    a_read_phase: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_rd |-> phase == BSTS_Q2 && !exec_nop)
        else $error("read outside second phase");
    a_phase_steps: assert property (
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> phase == 2'($past(phase) + 2'h1))
        else $error("phase did not advance by one");
    a_write_phase: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_wr |-> $past(mem_rd, 2) && !$past(mem_wr))
        else $error("write not two phases after read");
endmodule
`default_nettype wire

// *** rtl/bsts_pkg.sv ***
// package: constants and types for the bit set / bit test skip executor
package bsts_pkg;
    localparam int BSTS_OP_W = 16;
    localparam logic [3:0] BSTS_NIB_SET = 4'h8;
    localparam logic [3:0] BSTS_NIB_SKIP_CLR = 4'hB;
    localparam logic [3:0] BSTS_NIB_SKIP_SET = 4'hA;
    localparam int BSTS_NIB_POS = 12;
    localparam int BSTS_BIT_POS = 9;
    localparam int BSTS_ACC_POS = 8;
    localparam logic [7:0] BSTS_IDX_LIMIT = 8'h5F;
    localparam logic [11:0] BSTS_ADDR_RST = 12'h000;
    localparam logic [7:0] BSTS_DATA_RST = 8'h00;
    localparam logic [1:0] BSTS_Q1 = 2'h0;
    localparam logic [1:0] BSTS_Q2 = 2'h1;
    localparam logic [1:0] BSTS_Q3 = 2'h2;
    localparam logic [1:0] BSTS_Q4 = 2'h3;
    typedef enum logic [1:0] {
        BSTS_OP_NONE,
        BSTS_OP_SET,
        BSTS_OP_SKIP_CLR,
        BSTS_OP_SKIP_SET
    } bsts_op_e;
endpackage

// *** rtl/bsts_addr_resolve.sv ***
// module: resolves the 12-bit data address of a bit-oriented instruction
`timescale 1ns/1ps
`default_nettype none
module bsts_addr_resolve (
    input wire logic [7:0] reg_addr, // eight-bit file address field
    input wire logic access_flag, // a bit of the opcode
    input wire logic ext_set_en, // extended instruction set enabled
    input wire logic [3:0] bank_select_reg, // bank select register value
    input wire logic [11:0] index_base, // pointer used for indexed mode
    output logic [11:0] data_addr, // resolved data memory address
    output logic indexed // indexed literal offset mode used
);
    import bsts_pkg::*;
    always_comb begin
        indexed = 1'b0;
        if (access_flag) begin
            data_addr = {bank_select_reg, reg_addr};
        end else if (ext_set_en && reg_addr <= BSTS_IDX_LIMIT) begin
            indexed = 1'b1;
            data_addr = 12'(index_base + {4'h0, reg_addr});
        end else if (reg_addr[7]) begin
            // upper half of the access bank maps to the top page
            data_addr = {4'hF, reg_addr};
        end else begin
            data_addr = {4'h0, reg_addr};
        end
    end
endmodule
`default_nettype wire

// *** tb/bsts_exec_test.sv ***
// testbench: corner and random checks of the bit set / skip executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("BAD %0t %s", $time, msg); \
    end \
end
module bsts_exec_test;
    import bsts_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] opcode = 16'h0000;
    logic ext_set_en = 1'b0;
    logic [3:0] bank_select_reg = 4'h0;
    logic [11:0] index_base = 12'h000;
    logic [7:0] rd_data = 8'h00;
    logic [11:0] mem_addr;
    logic [7:0] wr_data;
    logic [1:0] phase;
    logic mem_rd, mem_wr, exec_nop, skip_taken, indexed_mode;
    int error_cnt = 0;
    int samples_checked = 0;
    int seed = 43314;
    logic [15:0] cops [6] = '{16'h8F0A, 16'h805F, 16'hB060, 16'hAE80,
                              16'hB7FF, 16'h9123};
    logic [7:0] crd [6] = '{8'h0A, 8'h00, 8'hFE, 8'h80, 8'h08, 8'hFF};

    bsts_exec i_bsts_exec (.clk_sys(clk_sys), .rst(rst), .opcode(opcode),
        .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg),
        .index_base(index_base), .rd_data(rd_data), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .wr_data(wr_data), .phase(phase),
        .exec_nop(exec_nop), .skip_taken(skip_taken),
        .indexed_mode(indexed_mode));

    always #20 clk_sys = ~clk_sys;

    function automatic logic idx_exp(input logic [7:0] f, input logic a);
        return ext_set_en && !a && (f <= BSTS_IDX_LIMIT);
    endfunction

    function automatic logic [11:0] addr_exp(input logic [7:0] f,
                                             input logic a);
        if (a) return {bank_select_reg, f};
        if (idx_exp(f, a)) return index_base + {4'h0, f};
        return (f < 8'h80) ? {4'h0, f} : {4'hF, f};
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    // one instruction from its decode slot; a skip is followed through the
    // whole forced nop, so the next call starts on the next decode slot
    task automatic run_op(input logic [15:0] op, input logic [7:0] rd);
        int n;
        logic [3:0] nib;
        logic bit_op, skip;
        logic [11:0] exp_a;
        n = 0;
        nib = op[15:12];
        bit_op = nib inside {BSTS_NIB_SET, BSTS_NIB_SKIP_CLR,
                             BSTS_NIB_SKIP_SET};
        skip = (nib == BSTS_NIB_SKIP_CLR && !rd[op[11:9]]) ||
               (nib == BSTS_NIB_SKIP_SET && rd[op[11:9]]);
        while (phase !== BSTS_Q1) begin
            step();
            n++;
            if (n > 20) begin
                `CHK(1'b0, 1'b1, "no decode slot")
                conclude();
            end
        end
        opcode = op;
        step();
        rd_data = rd;
        exp_a = addr_exp(op[7:0], op[8]);
        `CHK(mem_rd, 1'b1, "read strobe")
        `CHK(exec_nop, 1'b0, "nop outside a skip")
        if (bit_op && op[8]) begin
            `CHK(mem_addr, exp_a, "bank address")
        end else if (bit_op && idx_exp(op[7:0], 1'b0)) begin
            `CHK(mem_addr, exp_a, "indexed address")
        end else if (bit_op) begin
            `CHK(mem_addr, exp_a, "access address")
        end
        step();
        step();
        `CHK(phase, BSTS_Q4, "phase count")
        if (bit_op) begin
            `CHK(indexed_mode, idx_exp(op[7:0], op[8]), "indexed")
        end
        `CHK(mem_wr, nib == BSTS_NIB_SET, "write strobe")
        if (nib == BSTS_NIB_SET) begin
            `CHK(wr_data, rd | (8'h01 << op[11:9]), "set data")
        end
        `CHK(skip_taken, skip, "skip decision")
        step();
        rd_data = ~rd;
        if (skip) begin
            // a bit set offered in the discarded slot must be refused
            opcode = {BSTS_NIB_SET, op[11:0]};
            repeat (4) begin
                step();
                `CHK(exec_nop, 1'b1, "forced nop")
                `CHK(mem_wr, 1'b0, "nop writes")
                `CHK(mem_rd, 1'b0, "nop reads")
            end
        end
    endtask

    initial begin
        logic [3:0] nibs [4];
        logic [15:0] rop;
        nibs = '{BSTS_NIB_SET, BSTS_NIB_SKIP_CLR, BSTS_NIB_SKIP_SET, 4'h0};
        repeat (12) @(posedge clk_sys);
        #1;
        `CHK(phase, BSTS_Q1, "reset phase")
        rst = 1'b0;
        ext_set_en = 1'b1;
        bank_select_reg = 4'h5;
        index_base = 12'h3A0;
        for (int i = 0; i < 6; i++) run_op(cops[i], crd[i]);
        $display("corner test done");
        for (int i = 0; i < 40; i++) begin
            ext_set_en = 1'($random(seed));
            bank_select_reg = 4'($random(seed));
            index_base = 12'($random(seed));
            rop = {nibs[2'($random(seed))], 12'($random(seed))};
            run_op(rop, 8'($random(seed)));
        end
        $display("random test done");
        conclude();
    end
endmodule
`default_nettype wire
